// ===== rtl/pdc_phase_gate.sv
// Gate sequencing of one half-bridge: edge-triggered requests, deadtime,
// cross-conduction lockout and the low-side-first bootstrap condition.
// Assumes requests already synchronised to ref_clk and active high.
`timescale 1ns/10ps
module pdc_phase_gate
  import pdc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                hiReq,
  input  wire logic                loReq,
  input  wire logic                gateEnable,
  input  wire logic [DT_CNT_W-1:0] deadCycles,
  input  wire logic                useDeadtime,
  input  wire logic                useCross,
  output logic                     hiGate,
  output logic                     loGate
);

  typedef struct packed {
    logic                hiPrev;
    logic                loPrev;
    logic                hiPend;
    logic                loPend;
    logic                lsDone;
    logic                hiOn;
    logic                loOn;
    logic [DT_CNT_W-1:0] timer;
  } pdc_phase_s;

  localparam pdc_phase_s PH_RST = '0;

  pdc_phase_s s;
  pdc_phase_s next_s;

  always_comb begin
    next_s        = s;
    next_s.hiPrev = hiReq;
    next_s.loPrev = loReq;
    if (s.timer != '0) begin
      next_s.timer = DT_CNT_W'(s.timer - 1'b1);
    end
    // A pending turn-on fires once its deadtime has run out.
    if (s.loPend && s.timer == '0) begin
      next_s.loPend = 1'b0;
      next_s.loOn   = 1'b1;
    end
    if (s.hiPend && s.timer == '0) begin
      next_s.hiPend = 1'b0;
      next_s.hiOn   = s.lsDone;
    end
    if (!hiReq) begin
      next_s.hiOn   = 1'b0;
      next_s.hiPend = 1'b0;
    end
    if (!loReq) begin
      next_s.loOn   = 1'b0;
      next_s.loPend = 1'b0;
    end
    if (hiReq && !s.hiPrev) begin
      if (useCross) begin
        next_s.loOn   = 1'b0;
        next_s.loPend = 1'b0;
      end
      next_s.hiPend = 1'b1;
      next_s.timer  = useDeadtime ? deadCycles : '0;
    end
    // On simultaneous edges with the cross lockout on, the low side wins so the bootstrap charges.
    if (loReq && !s.loPrev) begin
      if (useCross) begin
        next_s.hiOn   = 1'b0;
        next_s.hiPend = 1'b0;
      end
      next_s.loPend = 1'b1;
      next_s.timer  = useDeadtime ? deadCycles : '0;
    end
    if (s.loOn) begin
      next_s.lsDone = 1'b1;
    end
    if (!gateEnable) begin
      next_s.hiOn   = 1'b0;
      next_s.loOn   = 1'b0;
      next_s.hiPend = 1'b0;
      next_s.loPend = 1'b0;
      next_s.lsDone = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= PH_RST;
    end else begin
      s <= next_s;
    end
  end

  assign hiGate = s.hiOn;
  assign loGate = s.loOn;

endmodule : pdc_phase_gate

// ===== rtl/pdc_pkg.sv
// Constants, types and helpers shared by the three-phase pre-driver logic.
// Assumes a 25 MHz ref_clk and a synchronous, active-high srst.
package pdc_pkg;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int DT_STEP_NS    = 50;
  localparam int DT_MAX_NS     = 12000;
  localparam int RESET_MAX_NS  = 77;
  localparam int DT_STEP_CYC   =
    (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT_MAX_CODE_I = DT_MAX_NS / DT_STEP_NS;
  localparam int RESET_MAX_CYC =
    (RESET_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : RESET_MAX_NS / CLK_PERIOD_NS;

  localparam int DT_CODE_W = 8;
  localparam int DT_CNT_W  = 10;
  localparam logic [DT_CODE_W-1:0] DT_MAX_CODE = DT_CODE_W'(DT_MAX_CODE_I);
  localparam logic [DT_CODE_W-1:0] DT_CODE_RST = 8'h14;

  // ***********************************************************************
  // Serial frame and commands
  // ***********************************************************************
  localparam int FRAME_BITS = 16;
  localparam int BIT_CNT_W  = 5;
  localparam int CMD_MSB    = 15;
  localparam int CMD_LSB    = 12;
  localparam logic [BIT_CNT_W-1:0] FRAME_LEN = BIT_CNT_W'(FRAME_BITS);

  typedef enum logic [3:0] {
    CMD_NOP       = 4'h0,
    CMD_MASK_LOW  = 4'h2,
    CMD_MASK_HIGH = 4'h3,
    CMD_DEADTIME  = 4'h4,
    CMD_MODE      = 4'h5,
    CMD_CLEAR_INT = 4'h6
  } pdc_cmd_e;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'h0,
    SPI_SHIFT = 2'h1,
    SPI_DONE  = 2'h3
  } pdc_spi_e;

  // ***********************************************************************
  // Faults and status
  // ***********************************************************************
  localparam int FAULT_W  = 8;
  localparam int MASK_W   = 4;
  localparam logic [MASK_W-1:0] MASK_RST = 4'hF;

  typedef struct packed {
    logic [FAULT_W-1:0] faults;
    logic               interrupt;
    logic               modeLocked;
    logic               simMode;
    logic               noDeadtime;
    logic               noCross;
    logic               overcurrent;
    logic [1:0]         spare;
  } pdc_status_s;

  // Every pin from outside the clock domain, bundled for the synchroniser.
  typedef struct packed {
    logic               enableOne;
    logic               enableTwo;
    logic               resetN;
    logic               porOk;
    logic               chipSelN;
    logic               serialClk;
    logic               serialIn;
    logic [2:0]         highInN;
    logic [2:0]         lowIn;
    logic [2:0]         compareIn;
    logic               overcurrentIn;
    logic [FAULT_W-1:0] faultIn;
  } pdc_pins_s;

  // Converts a deadtime code into clock cycles.
  function automatic logic [DT_CNT_W-1:0] dtCycles(
    input logic [DT_CODE_W-1:0] code);
    dtCycles = DT_CNT_W'(int'(code) * DT_STEP_CYC);
  endfunction : dtCycles

endpackage : pdc_pkg

// ===== rtl/pdc_predriver.sv
// Control logic of the three-phase pre-driver: pin synchronisers, reset
// and power-on handling, serial configuration port, fault interrupt and
// the three half-bridge sequencers.
// Assumes all pins except srst are asynchronous to ref_clk.
`timescale 1ns/10ps
module pdc_predriver
  import pdc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               resetN,
  input  wire logic               porOk,
  input  wire logic               enableOne,
  input  wire logic               enableTwo,
  input  wire logic               phaseAHighInN,
  input  wire logic               phaseALowIn,
  input  wire logic               phaseBHighInN,
  input  wire logic               phaseBLowIn,
  input  wire logic               phaseCHighInN,
  input  wire logic               phaseCLowIn,
  input  wire logic               chipSelN,
  input  wire logic               serialClk,
  input  wire logic               serialIn,
  input  wire logic               phaseACompareIn,
  input  wire logic               phaseBCompareIn,
  input  wire logic               phaseCCompareIn,
  input  wire logic               overcurrentIn,
  input  wire logic [FAULT_W-1:0] faultIn,
  output logic                    serialOut,
  output logic                    serialOutEn,
  output logic                    phaseAHighGate,
  output logic                    phaseALowGate,
  output logic                    phaseBHighGate,
  output logic                    phaseBLowGate,
  output logic                    phaseCHighGate,
  output logic                    phaseCLowGate,
  output logic                    gateDriveEn,
  output logic                    vddRegEnable,
  output logic                    biasEnable,
  output logic                    interruptOut,
  output logic                    phaseACompareOut,
  output logic                    phaseBCompareOut,
  output logic                    phaseCCompareOut,
  output logic                    overcurrentFlagOut
);

  // ***********************************************************************
  // State
  // ***********************************************************************
  typedef struct packed {
    pdc_pins_s               pins1;
    pdc_pins_s               pins2;
    logic                    sclkPrev;
    pdc_spi_e                spiState;
    logic [FRAME_BITS-1:0]   shiftIn;
    logic [FRAME_BITS-1:0]   shiftOut;
    logic [BIT_CNT_W-1:0]    bitCnt;
    logic                    soEn;
    logic                    soBit;
    logic [MASK_W-1:0]       maskLow;
    logic [MASK_W-1:0]       maskHigh;
    logic [DT_CODE_W-1:0]    dtCode;
    logic                    modeLocked;
    logic                    simMode;
    logic                    noDeadtime;
    logic                    noCross;
    logic [FAULT_W-1:0]      faultLatch;
    logic                    intFlag;
    logic [2:0]              compare;
    logic                    ovcFlag;
    logic                    gateOe;
    logic                    vddEn;
    logic                    biasEn;
  } pdc_top_s;

  localparam pdc_top_s TOP_RST = '{
    pins1:      '0,
    pins2:      '0,
    sclkPrev:   1'b0,
    spiState:   SPI_IDLE,
    shiftIn:    '0,
    shiftOut:   '0,
    bitCnt:     '0,
    soEn:       1'b0,
    soBit:      1'b0,
    maskLow:    MASK_RST,
    maskHigh:   MASK_RST,
    dtCode:     DT_CODE_RST,
    modeLocked: 1'b0,
    simMode:    1'b0,
    noDeadtime: 1'b0,
    noCross:    1'b0,
    faultLatch: '0,
    intFlag:    1'b0,
    compare:    '0,
    ovcFlag:    1'b0,
    gateOe:     1'b0,
    vddEn:      1'b0,
    biasEn:     1'b0
  };

  pdc_top_s    s;
  pdc_top_s    next_s;
  logic        logicRst;
  logic        gateEnable;
  logic        csActive;
  logic        sclkRise;
  logic        sclkFall;
  logic        clearInt;
  logic [3:0]  cmdCode;
  logic [11:0] cmdData;
  pdc_status_s status;
  logic [2:0]  hiReq;
  logic [2:0]  loReq;
  logic [2:0]  hiGate;
  logic [2:0]  loGate;

  // ***********************************************************************
  // Decoded conditions
  // ***********************************************************************
  // The internal logic is held in reset by the reset pin and by the
  // power-on monitor; everything below reads the synchronised copies.
  assign logicRst   = srst || !s.pins2.resetN || !s.pins2.porOk;
  assign gateEnable = s.pins2.enableOne && s.pins2.enableTwo
                      && !logicRst;
  assign csActive   = !s.pins2.chipSelN;
  assign sclkRise   = s.pins2.serialClk && !s.sclkPrev;
  assign sclkFall   = !s.pins2.serialClk && s.sclkPrev;
  assign cmdCode    = s.shiftIn[CMD_MSB:CMD_LSB];
  assign cmdData    = s.shiftIn[CMD_LSB-1:0];
  assign hiReq      = ~s.pins2.highInN;
  assign loReq      = s.pins2.lowIn;

  always_comb begin
    status             = '0;
    status.faults      = s.faultLatch;
    status.interrupt   = s.intFlag;
    status.modeLocked  = s.modeLocked;
    status.simMode     = s.simMode;
    status.noDeadtime  = s.noDeadtime;
    status.noCross     = s.noCross;
    status.overcurrent = s.ovcFlag;
  end

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb begin
    next_s   = s;
    clearInt = 1'b0;

    // Two-stage synchronisers for every asynchronous pin.
    next_s.pins1 = '{
      enableOne:     enableOne,
      enableTwo:     enableTwo,
      resetN:        resetN,
      porOk:         porOk,
      chipSelN:      chipSelN,
      serialClk:     serialClk,
      serialIn:      serialIn,
      highInN:       {phaseCHighInN, phaseBHighInN, phaseAHighInN},
      lowIn:         {phaseCLowIn, phaseBLowIn, phaseALowIn},
      compareIn:     {phaseCCompareIn, phaseBCompareIn, phaseACompareIn},
      overcurrentIn: overcurrentIn,
      faultIn:       faultIn
    };
    next_s.pins2    = s.pins1;
    next_s.sclkPrev = s.pins2.serialClk;

    next_s.compare = s.pins2.compareIn;
    next_s.ovcFlag = s.pins2.overcurrentIn;

    // Serial port.
    unique case (s.spiState)
      SPI_IDLE: begin
        if (csActive) begin
          next_s.spiState = SPI_SHIFT;
          next_s.shiftOut = status;
          next_s.soBit    = status[FRAME_BITS-1];
          next_s.bitCnt   = '0;
          next_s.soEn     = 1'b1;
        end
      end
      SPI_SHIFT: begin
        if (!csActive) begin
          next_s.spiState = SPI_DONE;
          next_s.soEn     = 1'b0;
        end else begin
          if (sclkFall && s.bitCnt < FRAME_LEN) begin
            next_s.shiftIn = {s.shiftIn[FRAME_BITS-2:0], s.pins2.serialIn};
            next_s.bitCnt  = BIT_CNT_W'(s.bitCnt + 1'b1);
          end
          // The first bit is already on the pin when select falls.
          if (sclkRise && s.bitCnt != '0) begin
            next_s.shiftOut = {s.shiftOut[FRAME_BITS-2:0], 1'b0};
            next_s.soBit    = s.shiftOut[FRAME_BITS-2];
          end
        end
      end
      SPI_DONE: begin
        next_s.spiState = SPI_IDLE;
        // A frame of 16 or more bits is executed on its first 16 bits; short ones are dropped.
        if (s.bitCnt == FRAME_LEN) begin
          case (cmdCode)
            CMD_MASK_LOW: begin
              next_s.maskLow = cmdData[MASK_W-1:0];
            end
            CMD_MASK_HIGH: begin
              next_s.maskHigh = cmdData[MASK_W-1:0];
            end
            CMD_DEADTIME: begin
              next_s.dtCode =
                (cmdData[DT_CODE_W-1:0] > DT_MAX_CODE) ?
                DT_MAX_CODE : cmdData[DT_CODE_W-1:0];
            end
            CMD_MODE: begin
              if (!s.modeLocked) begin
                next_s.modeLocked = 1'b1;
                next_s.simMode    = cmdData[2];
                next_s.noDeadtime = cmdData[1];
                next_s.noCross    = cmdData[0];
              end
            end
            CMD_CLEAR_INT: begin
              clearInt = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_s.spiState = SPI_IDLE;
        next_s.soEn     = 1'b0;
      end
    endcase

    // Fault capture; a new fault in the clearing cycle is kept.
    next_s.faultLatch = (clearInt ? '0 : s.faultLatch)
                        | s.pins2.faultIn;
    next_s.intFlag = (clearInt ? 1'b0 : s.intFlag)
                     | (|(s.pins2.faultIn & {s.maskHigh, s.maskLow}));

    next_s.gateOe = s.pins2.porOk;
    next_s.vddEn  = s.pins2.resetN;
    next_s.biasEn = s.pins2.resetN && s.pins2.porOk;

    // Held reset clears serial, configuration and fault state; synchronisers, compare, overcurrent and enable flags keep running.
    if (logicRst) begin
      next_s.spiState   = TOP_RST.spiState;
      next_s.shiftIn    = TOP_RST.shiftIn;
      next_s.shiftOut   = TOP_RST.shiftOut;
      next_s.bitCnt     = TOP_RST.bitCnt;
      next_s.soEn       = TOP_RST.soEn;
      next_s.soBit      = TOP_RST.soBit;
      next_s.maskLow    = TOP_RST.maskLow;
      next_s.maskHigh   = TOP_RST.maskHigh;
      next_s.dtCode     = TOP_RST.dtCode;
      next_s.modeLocked = TOP_RST.modeLocked;
      next_s.simMode    = TOP_RST.simMode;
      next_s.noDeadtime = TOP_RST.noDeadtime;
      next_s.noCross    = TOP_RST.noCross;
      next_s.faultLatch = TOP_RST.faultLatch;
      next_s.intFlag    = TOP_RST.intFlag;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= TOP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ***********************************************************************
  // Half-bridge sequencers
  // ***********************************************************************
  // The sequencers restart whenever the logic reset is held, so a pending
  // turn-on never survives a reset pulse.
  for (genvar p = 0; p < 3; p++) begin : g_phase
    pdc_phase_gate u_gate (
      .ref_clk     (ref_clk),
      .srst        (logicRst),
      .hiReq       (hiReq[p]),
      .loReq       (loReq[p]),
      .gateEnable  (gateEnable),
      .deadCycles  (dtCycles(s.dtCode)),
      .useDeadtime (!s.noDeadtime && !s.simMode),
      .useCross    (!s.noCross && !s.simMode),
      .hiGate      (hiGate[p]),
      .loGate      (loGate[p])
    );
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  assign serialOut          = s.soBit;
  assign serialOutEn        = s.soEn;
  assign phaseAHighGate     = hiGate[0];
  assign phaseALowGate      = loGate[0];
  assign phaseBHighGate     = hiGate[1];
  assign phaseBLowGate      = loGate[1];
  assign phaseCHighGate     = hiGate[2];
  assign phaseCLowGate      = loGate[2];
  assign gateDriveEn        = s.gateOe;
  assign vddRegEnable       = s.vddEn;
  assign biasEnable         = s.biasEn;
  assign interruptOut       = s.intFlag;
  assign phaseACompareOut   = s.compare[0];
  assign phaseBCompareOut   = s.compare[1];
  assign phaseCCompareOut   = s.compare[2];
  assign overcurrentFlagOut = s.ovcFlag;

endmodule : pdc_predriver

// ===== testbench/pdc_mcu_model.sv
// Serial master model of the motor controller firmware.
// Assumes a 25 MHz ref_clk; each serial clock level lasts 4 cycles.
`timescale 1ns/10ps
module pdc_mcu_model (
  input  wire logic ref_clk,
  input  wire logic serialOut,
  output logic      chipSelN,
  output logic      serialClk,
  output logic      serialIn
);
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // Runs one 16-bit frame; called just after a falling ref_clk edge.
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    chipSelN = 1'b0;
    repeat (6) @(negedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      serialClk = 1'b1;
      serialIn = tx[i];
      repeat (4) @(negedge ref_clk);
      rx[i] = serialOut;
      serialClk = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    chipSelN = 1'b1;
    serialIn = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : frame
endmodule : pdc_mcu_model

// ===== testbench/pdc_predriver_assertions.sv
// Concurrent checks on the ports of the pre-driver control logic.
// Assumes one ref_clk domain; bound to every pdc_predriver instance.
`timescale 1ns/10ps
module pdc_predriver_assertions
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic resetN,
  input wire logic porOk,
  input wire logic enableOne,
  input wire logic enableTwo,
  input wire logic chipSelN,
  input wire logic overcurrentIn,
  input wire logic serialOutEn,
  input wire logic phaseAHighGate,
  input wire logic phaseALowGate,
  input wire logic phaseBHighGate,
  input wire logic phaseBLowGate,
  input wire logic phaseCHighGate,
  input wire logic phaseCLowGate,
  input wire logic gateDriveEn,
  input wire logic vddRegEnable,
  input wire logic biasEnable,
  input wire logic interruptOut,
  input wire logic overcurrentFlagOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [5:0] gates;
  assign gates = {phaseAHighGate, phaseALowGate, phaseBHighGate,
                  phaseBLowGate, phaseCHighGate, phaseCLowGate};
  a_enables_off: assert property (
    (!enableOne || !enableTwo) [*5] |-> gates == 6'h00)
    else $error("gate on while an enable is low");
  a_no_shoot: assert property (!(gates[5] && gates[4]) &&
    !(gates[3] && gates[2]) && !(gates[1] && gates[0]))
    else $error("both gates of one phase on");
  a_reset_off: assert property (
    !resetN [*5] |-> gates == 6'h00 && !vddRegEnable && !biasEnable)
    else $error("outputs alive while reset pin low");
  a_por_off: assert property (
    !porOk [*5] |-> !gateDriveEn && !biasEnable && !serialOutEn)
    else $error("outputs alive below power-on level");
  a_so_tristate: assert property (
    chipSelN [*6] |-> !serialOutEn)
    else $error("serial output driven while deselected");
  a_so_driven: assert property (
    $fell(chipSelN) && porOk && resetN && biasEnable &&
    $past(biasEnable, 3) ##1 (!chipSelN && porOk && resetN) [*5]
    |-> serialOutEn)
    else $error("serial output not driven while selected");
  a_oc_follow: assert property (
    biasEnable [*4] |-> overcurrentFlagOut == $past(overcurrentIn, 3))
    else $error("overcurrent flag does not follow input");
  a_int_sticky: assert property (
    (interruptOut && chipSelN && resetN && porOk) [*7] |=> interruptOut)
    else $error("interrupt dropped without clear command");
  c_gate_on: cover property (|gates);
  c_int_set: cover property ($rose(interruptOut));
  c_so_on: cover property ($rose(serialOutEn));
endmodule : pdc_predriver_assertions

bind pdc_predriver pdc_predriver_assertions i_pdc_predriver_assertions (.*);

// ===== testbench/tb_top.sv
// Self-checking bench for the three-phase pre-driver control logic.
// Assumes the serial master model and the bound port checker.
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic       ref_clk, srst, resetN, porOk, enableOne, enableTwo;
  logic       overcurrentIn;
  logic [2:0] hiN, lo, cmpIn;
  logic [7:0] faultIn;
  wire        serialOut, serialOutEn, gateDriveEn, vddRegEnable;
  wire        biasEnable, interruptOut, ocOut, chipSelN, sclk, sdi;
  wire  [2:0] hiG, loG, cmpOut;
  int         errors = 0;
  int         n_checks = 0;

  pdc_predriver i_pdc_predriver (.ref_clk(ref_clk), .srst(srst),
    .resetN(resetN), .porOk(porOk), .enableOne(enableOne),
    .enableTwo(enableTwo), .phaseAHighInN(hiN[0]), .phaseALowIn(lo[0]),
    .phaseBHighInN(hiN[1]), .phaseBLowIn(lo[1]),
    .phaseCHighInN(hiN[2]), .phaseCLowIn(lo[2]), .chipSelN(chipSelN),
    .serialClk(sclk), .serialIn(sdi), .phaseACompareIn(cmpIn[0]),
    .phaseBCompareIn(cmpIn[1]), .phaseCCompareIn(cmpIn[2]),
    .overcurrentIn(overcurrentIn), .faultIn(faultIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn),
    .phaseAHighGate(hiG[0]), .phaseALowGate(loG[0]),
    .phaseBHighGate(hiG[1]), .phaseBLowGate(loG[1]),
    .phaseCHighGate(hiG[2]), .phaseCLowGate(loG[2]),
    .gateDriveEn(gateDriveEn), .vddRegEnable(vddRegEnable),
    .biasEnable(biasEnable), .interruptOut(interruptOut),
    .phaseACompareOut(cmpOut[0]), .phaseBCompareOut(cmpOut[1]),
    .phaseCCompareOut(cmpOut[2]), .overcurrentFlagOut(ocOut));
  pdc_mcu_model i_pdc_mcu_model (.ref_clk(ref_clk), .serialOut(serialOut),
    .chipSelN(chipSelN), .serialClk(sclk), .serialIn(sdi));

  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // ********************
  // Scenarios
  // ********************
  task automatic t_gates(input int p, input int d);
    hiN[p] = 1'b0;
    w(d + 10);
    `CHK(hiG[p], 1'b0)
    hiN[p] = 1'b1;
    lo[p] = 1'b1;
    w(d + 2);
    `CHK(loG[p], 1'b0)
    w(4);
    `CHK(loG[p], 1'b1)
    hiN[p] = 1'b0;
    w(6);
    `CHK({hiG[p], loG[p]}, 2'h0)
    w(d);
    `CHK(hiG[p], 1'b1)
    enableTwo = 1'b0;
    w(6);
    `CHK(hiG[p], 1'b0)
    {hiN[p], lo[p]} = 2'h2;
    w(4);
    lo[p] = 1'b1;
    w(d + 8);
    `CHK(loG[p], 1'b0)
    enableTwo = 1'b1;
    lo[p] = 1'b0;
    w(4);
    hiN[p] = 1'b0;
    w(d + 10);
    `CHK(hiG[p], 1'b0)
    hiN[p] = 1'b1;
    w(6);
  endtask : t_gates

  task automatic t_serial();
    logic [15:0] rx;
    i_pdc_mcu_model.frame(16'h0000, rx);
    `CHK(rx, 16'h0000)
    i_pdc_mcu_model.frame(16'h5000, rx);
    i_pdc_mcu_model.frame(16'h5007, rx);
    `CHK(rx, 16'h0040)
    i_pdc_mcu_model.frame(16'h4002, rx);
    `CHK(rx, 16'h0040)
  endtask : t_serial

  task automatic t_faults();
    logic [15:0] rx;
    faultIn = 8'h01;
    w(8);
    `CHK(interruptOut, 1'b1)
    faultIn = 8'h00;
    w(8);
    `CHK(interruptOut, 1'b1)
    i_pdc_mcu_model.frame(16'h6000, rx);
    `CHK(interruptOut, 1'b0)
    i_pdc_mcu_model.frame(16'h2000, rx);
    faultIn = 8'h02;
    w(8);
    `CHK(interruptOut, 1'b0)
    faultIn = 8'h20;
    {cmpIn, overcurrentIn} = 4'hB;
    w(8);
    `CHK(interruptOut, 1'b1)
    `CHK({cmpOut, ocOut}, 4'hB)
    faultIn = 8'h00;
    i_pdc_mcu_model.frame(16'h0000, rx);
    `CHK({rx[15:8] & 8'h22, rx[7:0]}, 16'h22C4)
    {cmpIn, overcurrentIn} = 4'h0;
  endtask : t_faults

  task automatic t_pins();
    logic [15:0] rx;
    lo[0] = 1'b1;
    w(12);
    `CHK(loG[0], 1'b1)
    resetN = 1'b0;
    w(5);
    `CHK({loG[0], vddRegEnable, biasEnable}, 3'h0)
    resetN = 1'b1;
    lo[0] = 1'b0;
    w(8);
    `CHK(vddRegEnable, 1'b1)
    porOk = 1'b0;
    fork
      i_pdc_mcu_model.frame(16'h6000, rx);
      begin
        w(12);
        `CHK({gateDriveEn, serialOutEn}, 2'h0)
      end
    join
    porOk = 1'b1;
    w(8);
    `CHK({gateDriveEn, biasEnable}, 2'h3)
    i_pdc_mcu_model.frame(16'h0000, rx);
    `CHK(rx, 16'h0000)
    i_pdc_mcu_model.frame(16'h5002, rx);
    i_pdc_mcu_model.frame(16'h0000, rx);
    `CHK(rx, 16'h0050)
    lo[1] = 1'b1;
    w(5);
    `CHK(loG[1], 1'b1)
    lo[1] = 1'b0;
    w(4);
  endtask : t_pins

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
  initial begin
    {srst, resetN, porOk, enableOne, enableTwo} = 5'h1F;
    {hiN, lo, cmpIn, overcurrentIn, faultIn} = {3'h7, 7'h00, 8'h00};
    w(16);
    srst = 1'b0;
    w(8);
    t_gates(0, 40);
    t_serial();
    t_gates(1, 4);
    t_gates(2, 4);
    t_faults();
    t_pins();
    end_of_test();
  end
endmodule : tb_top
